// [hdl/bfs_pkg.sv]
// shared constants and types for the buck fault sequencer
package bfs_pkg;

  // ---------------------------------------------------------------
  // clocking and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  // overvoltage must persist this long before the channel trips
  localparam int unsigned OVP_DELAY_NS = 10_000;
  // least time, so round up to whole cycles
  localparam int unsigned OVP_DELAY_CYC = (OVP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // power-good release delay in switching-clock cycles
  localparam int unsigned PG_DELAY_CYC = 64;
  // switching period in system clocks (about 400 kHz)
  localparam int unsigned SW_PERIOD_CYC = 62;
  // dead time between gate handovers, in system clocks
  localparam int unsigned DEAD_CYC = 2;

  // ---------------------------------------------------------------
  // widths and indices
  // ---------------------------------------------------------------
  localparam int unsigned NCH = 2;
  localparam int unsigned CH_ONE = 0;
  localparam int unsigned CH_TWO = 1;
  localparam int unsigned SW_W = 8;
  localparam int unsigned DT_W = 4;
  localparam int unsigned QUAL_W = 9;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic LOCKOUT_RST = 1'b1;
  localparam logic HS_RST = 1'b0;
  localparam logic LS_RST = 1'b1;

  // ---------------------------------------------------------------
  // channel states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BFS_OFF,
    BFS_SOFT_START,
    BFS_RUN,
    BFS_HICCUP,
    BFS_SOFT_STOP,
    BFS_OV_LATCH,
    BFS_SHORT_LATCH
  } bfs_state_t;

endpackage : bfs_pkg

// [hdl/bfs_qual_cnt.sv]
// qualifier counter: done after TARGET ticks with cond held
`timescale 1ns/1ps
module bfs_qual_cnt #(
  parameter int unsigned W = bfs_pkg::QUAL_W,
  parameter int unsigned TARGET = bfs_pkg::PG_DELAY_CYC
) (
  input wire logic clk,    // system clock
  input wire logic resetn, // async reset, active low
  input wire logic cond,   // condition being qualified
  input wire logic tick,   // count enable
  output logic done        // cond held for TARGET ticks
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!cond) begin
      cnt_nxt = '0;
    end else if (tick && (cnt_r != W'(TARGET))) begin
      cnt_nxt = cnt_r + W'(1);
    end
    done_nxt = cond && (cnt_nxt == W'(TARGET));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;

endmodule : bfs_qual_cnt

// [hdl/bfs_top.sv]
// supervisory and sequencing logic for a dual step-down controller
`timescale 1ns/1ps
module bfs_top #(
  parameter int unsigned SW_PERIOD = bfs_pkg::SW_PERIOD_CYC,
  parameter int unsigned DEAD = bfs_pkg::DEAD_CYC,
  parameter int unsigned PG_DELAY = bfs_pkg::PG_DELAY_CYC,
  parameter int unsigned OVP_DELAY = bfs_pkg::OVP_DELAY_CYC
) (
  input wire logic clk,                           // 25 MHz system clock
  input wire logic resetn,                        // async reset, active low
  input wire logic supply_above_low,              // internal_supply above 3.75 V
  input wire logic supply_above_high,             // internal_supply above 4.3 V
  input wire logic reference_ok,                  // reference above 0.64 V
  input wire logic thermal_fault,                 // over-temperature flag
  input wire logic tracking_variant,              // channel two tracks external reference
  input wire logic tracking_reference_above_045,  // tracking_reference_input above 0.45 V
  input wire logic enable_one,                    // channel one enable pin
  input wire logic enable_two,                    // channel two enable pin
  input wire logic ramp_reached_one,              // ramp crossed error amp, channel one
  input wire logic ramp_reached_two,              // ramp crossed error amp, channel two
  input wire logic peak_over_limit_one,           // peak current above current_limit_set, one
  input wire logic peak_over_limit_two,           // peak current above current_limit_set, two
  input wire logic feedback_sense_in_window_one,  // feedback within power-good window, one
  input wire logic feedback_sense_in_window_two,  // feedback within power-good window, two
  input wire logic feedback_sense_low_one,        // feedback 30 percent below nominal, one
  input wire logic feedback_sense_low_two,        // feedback 30 percent below nominal, two
  input wire logic feedback_sense_high_one,       // output 17 percent above reference, one
  input wire logic feedback_sense_high_two,       // output 17 percent above reference, two
  input wire logic ss_complete_one,               // soft-start ramp complete, one
  input wire logic ss_complete_two,               // soft-start ramp complete, two
  input wire logic ss_at_floor_one,               // soft-start cap below 50 mV, one
  input wire logic ss_at_floor_two,               // soft-start cap below 50 mV, two
  output logic high_side_gate_cmd_one,            // high-side gate command, one
  output logic high_side_gate_cmd_two,            // high-side gate command, two
  output logic low_side_gate_cmd_one,             // low-side gate command, one
  output logic low_side_gate_cmd_two,             // low-side gate command, two
  output logic ss_charge_one,                     // soft-start pull-up current on, one
  output logic ss_charge_two,                     // soft-start pull-up current on, two
  output logic ss_discharge_one,                  // soft-start pull-down current on, one
  output logic ss_discharge_two,                  // soft-start pull-down current on, two
  input wire logic power_good_one_in,             // power_good_one pin level
  output logic power_good_one_out,                // power_good_one drive value, always low
  output logic power_good_one_oe_n,               // low while pulling power_good_one low
  input wire logic power_good_two_in,             // power_good_two pin level
  output logic power_good_two_out,                // power_good_two drive value, always low
  output logic power_good_two_oe_n,               // low while pulling power_good_two low
  output logic termination_reference_out_en,      // termination reference amplifier on
  output logic ovp_fixed_threshold_two,           // channel two uses fixed 560 mV threshold
  output logic supply_lockout                     // lockout active
);

  // ---------------------------------------------------------------
  // supply lockout with hysteresis
  // ---------------------------------------------------------------
  logic lockout_r;
  logic lockout_nxt;
  always_comb begin
    lockout_nxt = lockout_r;
    if (!supply_above_low) begin
      lockout_nxt = 1'b1;
    end else if (supply_above_high) begin
      lockout_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lockout_r <= bfs_pkg::LOCKOUT_RST;
    end else begin
      lockout_r <= lockout_nxt;
    end
  end
  assign supply_lockout = lockout_r;

  // ---------------------------------------------------------------
  // switching clock divider
  // ---------------------------------------------------------------
  logic [bfs_pkg::SW_W-1:0] sw_cnt_r;
  logic [bfs_pkg::SW_W-1:0] sw_cnt_nxt;
  logic sw_tick_r;
  logic sw_tick_nxt;
  always_comb begin
    sw_tick_nxt = (sw_cnt_r == bfs_pkg::SW_W'(SW_PERIOD - 1));
    sw_cnt_nxt = sw_tick_nxt ? '0 : sw_cnt_r + bfs_pkg::SW_W'(1);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sw_cnt_r <= '0;
      sw_tick_r <= 1'b0;
    end else begin
      sw_cnt_r <= sw_cnt_nxt;
      sw_tick_r <= sw_tick_nxt;
    end
  end

  // ---------------------------------------------------------------
  // per-channel input and output vectors
  // ---------------------------------------------------------------
  logic [bfs_pkg::NCH-1:0] en_v;
  logic [bfs_pkg::NCH-1:0] ramp_v;
  logic [bfs_pkg::NCH-1:0] peak_v;
  logic [bfs_pkg::NCH-1:0] win_v;
  logic [bfs_pkg::NCH-1:0] fbl_v;
  logic [bfs_pkg::NCH-1:0] fbh_v;
  logic [bfs_pkg::NCH-1:0] ssc_v;
  logic [bfs_pkg::NCH-1:0] ssf_v;
  logic [bfs_pkg::NCH-1:0] hs_v;
  logic [bfs_pkg::NCH-1:0] ls_v;
  logic [bfs_pkg::NCH-1:0] chg_v;
  logic [bfs_pkg::NCH-1:0] dis_v;
  logic [bfs_pkg::NCH-1:0] pg_v;
  logic [bfs_pkg::NCH-1:0] int_en_v;
  logic [bfs_pkg::NCH-1:0] uv_trip_v;
  logic [bfs_pkg::NCH-1:0] uv_arm_v;
  logic [bfs_pkg::NCH-1:0] short_v;

  assign en_v = {enable_two, enable_one};
  assign ramp_v = {ramp_reached_two, ramp_reached_one};
  assign peak_v = {peak_over_limit_two, peak_over_limit_one};
  assign win_v = {feedback_sense_in_window_two, feedback_sense_in_window_one};
  assign fbl_v = {feedback_sense_low_two, feedback_sense_low_one};
  assign fbh_v = {feedback_sense_high_two, feedback_sense_high_one};
  assign ssc_v = {ss_complete_two, ss_complete_one};
  assign ssf_v = {ss_at_floor_two, ss_at_floor_one};

  // tracking channel needs its reference up before tripping
  assign uv_arm_v[bfs_pkg::CH_ONE] = 1'b1;
  assign uv_arm_v[bfs_pkg::CH_TWO] = ~tracking_variant | tracking_reference_above_045;
  // on tracking parts, a short on one latches two off
  assign short_v[bfs_pkg::CH_ONE] = 1'b0;
  assign short_v[bfs_pkg::CH_TWO] = tracking_variant & uv_trip_v[bfs_pkg::CH_ONE];

  // ---------------------------------------------------------------
  // channel sequencer and gate driver
  // ---------------------------------------------------------------
  for (genvar c = 0; c < bfs_pkg::NCH; c++) begin : g_ch
    bfs_pkg::bfs_state_t st_r;
    bfs_pkg::bfs_state_t st_nxt;
    logic pwm_req_r;
    logic pwm_req_nxt;
    logic current_limit_set_r;
    logic current_limit_set_nxt;
    logic hs_r;
    logic hs_nxt;
    logic ls_r;
    logic ls_nxt;
    logic [bfs_pkg::DT_W-1:0] dt_r;
    logic [bfs_pkg::DT_W-1:0] dt_nxt;
    logic switching;
    logic tgt_hs;
    logic tgt_ls;
    logic dead_done;
    logic ovp_done;
    logic pg_cond;
    assign int_en_v[c] = en_v[c] & ~lockout_r & reference_ok & ~thermal_fault;
    // limit, low feedback and completed soft-start
    assign uv_trip_v[c] = (st_r == bfs_pkg::BFS_RUN) & (current_limit_set_r | peak_v[c]) & fbl_v[c] & ssc_v[c] & uv_arm_v[c];
    assign switching = (st_r == bfs_pkg::BFS_SOFT_START) || (st_r == bfs_pkg::BFS_RUN) ||
                       (st_r == bfs_pkg::BFS_SOFT_STOP);
    assign dead_done = (dt_r == bfs_pkg::DT_W'(DEAD));
    // overvoltage must persist before the latch
    bfs_qual_cnt #(
      .W(bfs_pkg::QUAL_W),
      .TARGET(OVP_DELAY)
    ) u_ovp_qual (
      .clk(clk),
      .resetn(resetn),
      .cond(fbh_v[c] & switching),
      .tick(1'b1),
      .done(ovp_done)
    );
    // count switching cycles inside the window
    assign pg_cond = win_v[c] & ~lockout_r & ~thermal_fault &
                     ((st_r == bfs_pkg::BFS_RUN) || (st_r == bfs_pkg::BFS_SOFT_START));
    bfs_qual_cnt #(
      .W(bfs_pkg::QUAL_W),
      .TARGET(PG_DELAY)
    ) u_pg_qual (
      .clk(clk),
      .resetn(resetn),
      .cond(pg_cond),
      .tick(sw_tick_r),
      .done(pg_v[c])
    );
    always_comb begin
      st_nxt = st_r;
      case (st_r)
        // internal enable starts switching and soft-start
        bfs_pkg::BFS_OFF: if (int_en_v[c]) begin
          st_nxt = bfs_pkg::BFS_SOFT_START;
        end
        bfs_pkg::BFS_SOFT_START: if (ssc_v[c]) begin
          st_nxt = bfs_pkg::BFS_RUN;
        end
        // every completed restart may trip again
        bfs_pkg::BFS_RUN: if (uv_trip_v[c]) begin
          st_nxt = bfs_pkg::BFS_HICCUP;
        end
        // restart with fresh soft-start at 50 mV
        bfs_pkg::BFS_HICCUP: if (ssf_v[c]) begin
          st_nxt = bfs_pkg::BFS_SOFT_START;
        end
        // parked with low-side on after soft-stop
        bfs_pkg::BFS_SOFT_STOP: if (ssf_v[c]) begin
          st_nxt = bfs_pkg::BFS_OFF;
        end
        bfs_pkg::BFS_OV_LATCH, bfs_pkg::BFS_SHORT_LATCH: if (!en_v[c]) begin
          st_nxt = bfs_pkg::BFS_OFF;
        end
        default: st_nxt = bfs_pkg::BFS_OFF;
      endcase
      if (!en_v[c] && ((st_r == bfs_pkg::BFS_SOFT_START) || (st_r == bfs_pkg::BFS_RUN) ||
                       (st_r == bfs_pkg::BFS_HICCUP))) begin
        st_nxt = bfs_pkg::BFS_SOFT_STOP;
      end
      if (ovp_done) begin
        st_nxt = bfs_pkg::BFS_OV_LATCH;
      end
      // hold two off until its enable toggles
      if (short_v[c] && (st_r != bfs_pkg::BFS_OFF) && (st_r != bfs_pkg::BFS_OV_LATCH)) begin
        st_nxt = bfs_pkg::BFS_SHORT_LATCH;
      end
      // thermal stops the converter and resets soft-start
      if (thermal_fault && (st_r != bfs_pkg::BFS_OV_LATCH) && (st_r != bfs_pkg::BFS_SHORT_LATCH)) begin
        st_nxt = bfs_pkg::BFS_OFF;
      end
      if (lockout_r) begin
        st_nxt = bfs_pkg::BFS_OFF;
      end
    end
    always_comb begin
      // on at each switching clock, off at the ramp crossing
      pwm_req_nxt = pwm_req_r;
      if (!switching) begin
        pwm_req_nxt = 1'b0;
      end else if (sw_tick_r) begin
        pwm_req_nxt = 1'b1;
      end else if (ramp_v[c] || peak_v[c]) begin
        pwm_req_nxt = 1'b0;
      end
      current_limit_set_nxt = sw_tick_r ? peak_v[c] : (current_limit_set_r | peak_v[c]);
    end
    always_comb begin
      tgt_hs = 1'b0;
      tgt_ls = 1'b1;
      if (lockout_r) begin
        tgt_ls = 1'b1;
      end else if (thermal_fault || (st_r == bfs_pkg::BFS_HICCUP) || (st_r == bfs_pkg::BFS_SHORT_LATCH)) begin
        // both gates low while hot or in hiccup
        tgt_ls = 1'b0;
      end else if (switching) begin
        tgt_hs = pwm_req_r & ~peak_v[c];
        tgt_ls = ~pwm_req_r;
      end
      // turn-off is immediate, turn-on waits out the dead time
      hs_nxt = tgt_hs & (hs_r | (~ls_r & dead_done));
      ls_nxt = tgt_ls & (ls_r | (~hs_r & dead_done));
      dt_nxt = dead_done ? dt_r : dt_r + bfs_pkg::DT_W'(1);
      if ((hs_r && !hs_nxt) || (ls_r && !ls_nxt)) begin
        dt_nxt = '0;
      end
    end
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        st_r <= bfs_pkg::BFS_OFF;
        pwm_req_r <= 1'b0;
        current_limit_set_r <= 1'b0;
        hs_r <= bfs_pkg::HS_RST;
        ls_r <= bfs_pkg::LS_RST;
        dt_r <= '0;
      end else begin
        st_r <= st_nxt;
        pwm_req_r <= pwm_req_nxt;
        current_limit_set_r <= current_limit_set_nxt;
        hs_r <= hs_nxt;
        ls_r <= ls_nxt;
        dt_r <= dt_nxt;
      end
    end
    assign hs_v[c] = hs_r;
    assign ls_v[c] = ls_r;
    assign chg_v[c] = (st_r == bfs_pkg::BFS_SOFT_START) || (st_r == bfs_pkg::BFS_RUN);
    // idle states discharge the soft-start cap; hiccup and soft-stop both wait for it to fall below 50 mV
    assign dis_v[c] = ~chg_v[c];
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign high_side_gate_cmd_one = hs_v[bfs_pkg::CH_ONE];
  assign high_side_gate_cmd_two = hs_v[bfs_pkg::CH_TWO];
  assign low_side_gate_cmd_one = ls_v[bfs_pkg::CH_ONE];
  assign low_side_gate_cmd_two = ls_v[bfs_pkg::CH_TWO];
  assign ss_charge_one = chg_v[bfs_pkg::CH_ONE];
  assign ss_charge_two = chg_v[bfs_pkg::CH_TWO];
  assign ss_discharge_one = dis_v[bfs_pkg::CH_ONE];
  assign ss_discharge_two = dis_v[bfs_pkg::CH_TWO];
  // open drain: only ever pulls low, released as high impedance
  assign power_good_one_out = 1'b0;
  assign power_good_two_out = 1'b0;
  assign power_good_one_oe_n = pg_v[bfs_pkg::CH_ONE];
  assign power_good_two_oe_n = pg_v[bfs_pkg::CH_TWO];
  // termination amplifier follows the internal enable of two on tracking parts
  assign termination_reference_out_en = tracking_variant & int_en_v[bfs_pkg::CH_TWO];
  // fixed threshold while the tracking reference is low
  assign ovp_fixed_threshold_two = tracking_variant & ~tracking_reference_above_045;

endmodule : bfs_top

// [verif/bfs_power_stage.sv]
// behavioural power stage and soft-start capacitor for one channel
`timescale 1ns/1ps
module bfs_power_stage #(
  parameter int unsigned SS_TOP = 6
) (
  input wire logic clk,      // system clock
  input wire logic resetn,   // async reset, active low
  input wire logic hs,       // high-side gate command
  input wire logic chg,      // soft-start pull-up on
  input wire logic dis,      // soft-start pull-down on
  input wire logic oe_n,     // power-good pull-down released
  input wire logic overload, // load beyond the limit
  input wire logic overvolt, // output driven too high
  output logic ramp,         // ramp met error amp
  output logic ss_done,      // soft-start complete
  output logic ss_floor,     // soft-start cap at floor
  output logic in_win,       // feedback in window
  output logic fb_low,       // feedback far below nominal
  output logic fb_high,      // output above reference
  output logic peak,         // peak current over limit
  output logic pg_pin        // power-good pin level
);
  logic [3:0] lvl_r;
  logic [3:0] on_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lvl_r <= 4'h0;
      on_r <= 4'h0;
    end else begin
      if (chg && lvl_r < 4'(SS_TOP)) lvl_r <= lvl_r + 4'h1;
      else if (dis && lvl_r != 4'h0) lvl_r <= lvl_r - 4'h1;
      on_r <= hs ? on_r + 4'h1 : 4'h0;
    end
  end
  assign ramp = on_r >= 4'h3;
  assign ss_done = lvl_r == 4'(SS_TOP);
  assign ss_floor = lvl_r == 4'h0;
  // the output only reaches the window once the soft-start ramp is up
  assign in_win = ss_done && !overload && !overvolt;
  assign fb_low = overload;
  assign fb_high = overvolt;
  // overcurrent is only sensed while the high side conducts
  assign peak = overload && hs;
  assign pg_pin = oe_n ? 1'b1 : 1'b0;
endmodule : bfs_power_stage

// [verif/bfs_top_props.sv]
// concurrent checks on the buck fault sequencer ports
`timescale 1ns/1ps
module bfs_top_props #(
  parameter int unsigned SW_PERIOD = bfs_pkg::SW_PERIOD_CYC,
  parameter int unsigned PG_DELAY = bfs_pkg::PG_DELAY_CYC
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic supply_above_low, // supply above low level
  input wire logic supply_above_high, // supply above high level
  input wire logic reference_ok, // reference good
  input wire logic thermal_fault, // over-temperature
  input wire logic tracking_variant, // channel two tracks
  input wire logic tracking_reference_above_045, // tracking reference high
  input wire logic enable_one, // channel one enable
  input wire logic enable_two, // channel two enable
  input wire logic peak_over_limit_one, // peak current, one
  input wire logic feedback_sense_in_window_one, // window, one
  input wire logic high_side_gate_cmd_one, // high side, one
  input wire logic high_side_gate_cmd_two, // high side, two
  input wire logic low_side_gate_cmd_one, // low side, one
  input wire logic low_side_gate_cmd_two, // low side, two
  input wire logic ss_charge_one, // soft-start charge, one
  input wire logic ss_charge_two, // soft-start charge, two
  input wire logic power_good_one_oe_n, // power-good release, one
  input wire logic power_good_two_oe_n, // power-good release, two
  input wire logic termination_reference_out_en, // termination amp on
  input wire logic ovp_fixed_threshold_two, // fixed threshold select
  input wire logic supply_lockout // lockout active
);
  // a release needs 64 ticks of unbroken window, so at least 63 periods
  localparam int unsigned PG_MIN = (PG_DELAY - 1) * SW_PERIOD;
  int unsigned win_cnt_r;
  int unsigned win_cnt_nxt;
  always_comb begin
    win_cnt_nxt = feedback_sense_in_window_one ? win_cnt_r + 1 : 0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) win_cnt_r <= 0;
    else win_cnt_r <= win_cnt_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  gate_overlap_a:
    assert property (!(high_side_gate_cmd_one && low_side_gate_cmd_one) &&
      !(high_side_gate_cmd_two && low_side_gate_cmd_two)) else $error("both gates on");
  dead_time_a:
    assert property ($fell(low_side_gate_cmd_one) |-> !high_side_gate_cmd_one [*2]) else $error("no dead time");
  lockout_set_a:
    assert property (!supply_above_low |=> supply_lockout) else $error("lockout not set");
  lockout_hold_a:
    assert property (supply_above_low && !supply_above_high |=> $stable(supply_lockout)) else $error("no hysteresis");
  lockout_outs_a:
    assert property (supply_lockout [*5] |-> !high_side_gate_cmd_one && low_side_gate_cmd_one &&
      !high_side_gate_cmd_two && low_side_gate_cmd_two && !power_good_one_oe_n && !power_good_two_oe_n)
      else $error("lockout outputs");
  start_cond_a:
    assert property ($rose(ss_charge_one) |-> $past(enable_one) && !$past(supply_lockout) &&
      $past(reference_ok) && !$past(thermal_fault)) else $error("start without enable");
  pg_delay_a:
    assert property ($rose(power_good_one_oe_n) |-> win_cnt_r >= PG_MIN) else $error("power good early");
  pg_drop_a:
    assert property (!feedback_sense_in_window_one |=> !power_good_one_oe_n) else $error("power good kept");
  thermal_stop_a:
    assert property (thermal_fault [*4] |-> !high_side_gate_cmd_one && !high_side_gate_cmd_two &&
      !power_good_one_oe_n && !power_good_two_oe_n && !ss_charge_one && !ss_charge_two)
      else $error("thermal stop");
  peak_cut_a:
    assert property (peak_over_limit_one |=> !high_side_gate_cmd_one) else $error("pulse not cut");
  ovp_select_a:
    assert property (ovp_fixed_threshold_two == (tracking_variant && !tracking_reference_above_045))
      else $error("bad threshold");
  term_en_a:
    assert property (termination_reference_out_en |-> tracking_variant && enable_two) else $error("amp on");
  cover property ($rose(power_good_one_oe_n));
  cover property ($fell(ss_charge_one) && enable_one && !thermal_fault && supply_above_low);
  cover property (thermal_fault [*4]);
endmodule : bfs_top_props
bind bfs_top bfs_top_props #(.SW_PERIOD(SW_PERIOD), .PG_DELAY(PG_DELAY)) bfs_top_props_i (.*);

// [verif/bfs_top_bench.sv]
// self-checking bench for the buck fault sequencer
`timescale 1ns/1ps
module bfs_top_bench;
  localparam int SWP = 8;
  logic clk, resetn, supply_above_low, supply_above_high, reference_ok, thermal_fault;
  logic tracking_variant, tracking_reference_above_045, enable_one, enable_two;
  logic ramp_reached_one, ramp_reached_two, peak_over_limit_one, peak_over_limit_two;
  logic feedback_sense_in_window_one, feedback_sense_in_window_two, feedback_sense_low_one;
  logic feedback_sense_low_two, feedback_sense_high_one, feedback_sense_high_two;
  logic ss_complete_one, ss_complete_two, ss_at_floor_one, ss_at_floor_two;
  logic high_side_gate_cmd_one, high_side_gate_cmd_two, low_side_gate_cmd_one, low_side_gate_cmd_two;
  logic ss_charge_one, ss_charge_two, ss_discharge_one, ss_discharge_two;
  logic power_good_one_in, power_good_one_out, power_good_one_oe_n;
  logic power_good_two_in, power_good_two_out, power_good_two_oe_n;
  logic termination_reference_out_en, ovp_fixed_threshold_two, supply_lockout;
  logic ovl_one, ovl_two, ovv_one, ovv_two, prev;
  int n_fail, n_tests, i, n_rise;
  // inputs low, high, tracking, ref045, enable_two, ref_ok; then lockout, fixed, amp
  logic [8:0] rows [9] = '{9'h00c, 9'h10c, 9'h188, 9'h108, 9'h1ca, 9'h1e8, 9'h1f9, 9'h1b8, 9'h1f0};
  bfs_top #(.SW_PERIOD(SWP), .OVP_DELAY(10)) bfs_top_i (.*);
  bfs_power_stage stage_one_i (.clk(clk), .resetn(resetn), .hs(high_side_gate_cmd_one), .chg(ss_charge_one),
    .dis(ss_discharge_one), .oe_n(power_good_one_oe_n), .overload(ovl_one), .overvolt(ovv_one),
    .ramp(ramp_reached_one), .ss_done(ss_complete_one), .ss_floor(ss_at_floor_one),
    .in_win(feedback_sense_in_window_one), .fb_low(feedback_sense_low_one),
    .fb_high(feedback_sense_high_one), .peak(peak_over_limit_one), .pg_pin(power_good_one_in));
  bfs_power_stage stage_two_i (.clk(clk), .resetn(resetn), .hs(high_side_gate_cmd_two), .chg(ss_charge_two),
    .dis(ss_discharge_two), .oe_n(power_good_two_oe_n), .overload(ovl_two), .overvolt(ovv_two),
    .ramp(ramp_reached_two), .ss_done(ss_complete_two), .ss_floor(ss_at_floor_two),
    .in_win(feedback_sense_in_window_two), .fb_low(feedback_sense_low_two),
    .fb_high(feedback_sense_high_two), .peak(peak_over_limit_two), .pg_pin(power_good_two_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // the sequence needs under 5000 cycles
  initial begin
    #400_000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {resetn, supply_above_low, supply_above_high, thermal_fault, tracking_variant} = '0;
    {tracking_reference_above_045, enable_one, enable_two, ovl_one, ovl_two, ovv_one, ovv_two} = '0;
    reference_ok = 1'b1;
    n_fail = 0;
    n_tests = 0;
    step(3);
    check({high_side_gate_cmd_one, low_side_gate_cmd_one, power_good_one_oe_n, supply_lockout}, 4'h5);
    resetn = 1'b1;
    for (i = 0; i < 9; i++) begin
      {supply_above_low, supply_above_high, tracking_variant, tracking_reference_above_045, enable_two,
        reference_ok} = rows[i][8:3];
      step(2);
      check({1'b0, supply_lockout, ovp_fixed_threshold_two, termination_reference_out_en},
        {1'b0, rows[i][2:0]});
    end
    reference_ok = 1'b1;
    enable_one = 1'b1;
    step(1);
    check({3'h0, ss_charge_one}, 4'h1);
    for (i = 0; i < 3 * SWP && high_side_gate_cmd_one !== 1'b1; i++) step(1);
    check({3'h0, high_side_gate_cmd_one}, 4'h1);
    for (i = 0; i < 80 * SWP && power_good_one_oe_n !== 1'b1; i++) step(1);
    check({power_good_one_out, power_good_two_out, power_good_one_oe_n, power_good_one_in}, 4'h3);
    thermal_fault = 1'b1;
    step(4);
    check({high_side_gate_cmd_one, low_side_gate_cmd_one, power_good_one_oe_n, ss_charge_two}, 4'h0);
    thermal_fault = 1'b0;
    step(3);
    check({3'h0, ss_charge_one}, 4'h1);
    for (i = 0; i < 40 && !(ss_complete_one && ss_complete_two); i++) step(1);
    step(2);
    // overload on output one: hiccup there, output two latched off
    ovl_one = 1'b1;
    n_rise = 0;
    prev = 1'b1;
    for (i = 0; i < 30 * SWP; i++) begin
      step(1);
      if (ss_charge_one === 1'b1 && prev === 1'b0) n_rise++;
      prev = ss_charge_one;
    end
    check({3'h0, n_rise >= 2}, 4'h1);
    ovl_one = 1'b0;
    step(40);
    check({high_side_gate_cmd_two, low_side_gate_cmd_two, ss_charge_two, 1'b0}, 4'h0);
    tracking_reference_above_045 = 1'b0;
    enable_two = 1'b0;
    step(2);
    enable_two = 1'b1;
    for (i = 0; i < 40 && ss_complete_two !== 1'b1; i++) step(1);
    check({3'h0, ss_complete_two}, 4'h1);
    ovl_two = 1'b1;
    step(10 * SWP);
    check({3'h0, ss_discharge_two}, 4'h0);
    tracking_reference_above_045 = 1'b1;
    for (i = 0; i < 3 * SWP && ss_discharge_two !== 1'b1; i++) step(1);
    check({3'h0, ss_discharge_two}, 4'h1);
    ovl_two = 1'b0;
    for (i = 0; i < 40 && ss_complete_one !== 1'b1; i++) step(1);
    ovv_one = 1'b1;
    step(20);
    check({high_side_gate_cmd_one, low_side_gate_cmd_one, ss_charge_one, 1'b0}, 4'h4);
    ovv_one = 1'b0;
    step(3 * SWP);
    check({high_side_gate_cmd_one, low_side_gate_cmd_one, ss_charge_one, 1'b0}, 4'h4);
    enable_one = 1'b0;
    step(2);
    enable_one = 1'b1;
    for (i = 0; i < 40 && ss_complete_one !== 1'b1; i++) step(1);
    check({3'h0, ss_complete_one}, 4'h1);
    enable_one = 1'b0;
    step(2);
    check({2'h0, ss_discharge_one, ss_charge_one}, 4'h2);
    for (i = 0; i < 40 && ss_at_floor_one !== 1'b1; i++) step(1);
    step(6);
    check({high_side_gate_cmd_one, low_side_gate_cmd_one, ss_charge_one, 1'b0}, 4'h4);
    enable_one = 1'b1;
    step(4 * SWP);
    {supply_above_low, supply_above_high} = 2'h0;
    step(8);
    check({high_side_gate_cmd_one, low_side_gate_cmd_one, power_good_one_oe_n, supply_lockout}, 4'h5);
    {supply_above_low, supply_above_high} = 2'h3;
    step(4 * SWP);
    resetn = 1'b0;
    step(1);
    check({high_side_gate_cmd_one, low_side_gate_cmd_one, power_good_one_oe_n, supply_lockout}, 4'h5);
    resetn = 1'b1;
    step(2);
    tally_and_finish();
  end
endmodule : bfs_top_bench
